//--- hw/lak_pkg.sv
// Constants and types for the link auth interrupt and key verify block
//
// Functional notes
// - Enable bit 6 gates the receiver detect interrupt.
// - Detect source select 1 makes detect follow receiver lock instead.
// - Enable bit 5 lets the downstream receiver interrupt through.
// - Enable bit 4 gates the key list ready interrupt.
// - Enable bit 3 gates the key vector ready interrupt.
// - Enable bit 2 gates auth fail or auth loss interrupt.
// - Enable bit 1 gates the auth pass interrupt.
// - Global enable bit 0 gates the interrupt output; enables reset zero.
// - Status bit 6 reports receiver detect, bit 5 downstream interrupt.
// - Status bit 4 reports key list ready.
// - Status bit 3 reports key vector ready.
// - Status bit 2 reports auth fail or loss, bit 1 auth pass.
// - Status bit 0 set while any enabled source is indicating.
// - Writing verify bit 2 starts key store hash and digest compare.
// - Verify start bit clears itself when verification finishes.
// - Read-only bit 6 shows verification done.
// - Bit 7 gives verify result, valid only while done is set.
// - Rising pulse enable bit 6, reset 1, pulses on detect rise.
// - Falling pulse field bits 5-2, reset zero, pulses on detect fall.
// - Both edge enables together pulse on both edges.
// - Edge selection applies to both lock and link detect sources.
// - Downstream interrupt input is active low; 0 means pending.
// - Key vector ready flag clears when the status register is read.
package lak_pkg;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hc6;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hc7;
   localparam logic [7:0] ADDR_VERIFY_CTRL = 8'hc8;
   localparam logic [7:0] ADDR_EDGE_CONFIG = 8'hcd;
   localparam logic [7:0] ADDR_BLUE_VALUE = 8'hce;
   localparam logic [7:0] RESET_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] RESET_EDGE_CONFIG = 8'h40;
   localparam logic [7:0] RESET_BLUE_VALUE = 8'hff;
   localparam logic [7:0] MASK_IRQ_ENABLE = 8'h7f;
   localparam int BIT_DETECT = 6;
   localparam int BIT_DOWNSTREAM = 5;
   localparam int BIT_LIST_READY = 4;
   localparam int BIT_VECTOR_READY = 3;
   localparam int BIT_AUTH_FAIL = 2;
   localparam int BIT_AUTH_PASS = 1;
   localparam int BIT_GLOBAL = 0;
   localparam int BIT_VERIFY_PASSED = 7;
   localparam int BIT_VERIFY_DONE = 6;
   localparam int BIT_VERIFY_START = 2;
   localparam int BIT_RISING_PULSE = 6;
   localparam int FALL_LSB = 2;
   localparam int FALL_MSB = 5;
   localparam int KEY_COUNT = 8;
   localparam int KEY_WIDTH = 32;

   // Event sources from the receiver pins and the authentication engine
   typedef struct packed {
      logic receiverDetect;
      logic receiverLock;
      logic downstreamIrqN;
      logic keyListReady;
      logic keyVectorReady;
      logic authFail;
      logic authPass;
   } lak_events_type;

   // Register bus request
   typedef struct packed {
      logic [7:0] address;
      logic [7:0] writeData;
      logic writeStrobe;
      logic readStrobe;
   } lak_bus_type;
endpackage

//--- hw/lak_link_auth_irq.sv
// Interrupt, edge pulse and key store verify logic of the auth transmitter
`timescale 1ns/1ps
module lak_link_auth_irq #(
   parameter int KEY_COUNT = lak_pkg::KEY_COUNT,
   parameter int KEY_WIDTH = lak_pkg::KEY_WIDTH,
   parameter logic [KEY_WIDTH-1:0] STORED_DIGEST = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire lak_pkg::lak_bus_type bus,
   output logic [7:0] readData,
   // Pins and engine events
   input wire lak_pkg::lak_events_type events,
   input wire logic detectSourceSelect,
   // Key store read port, one cycle latency
   output logic [7:0] keyIndex,
   input wire logic [KEY_WIDTH-1:0] keyWord,
   // Outputs
   output logic irqOut,
   output logic keyVectorAccepted,
   output logic [7:0] fillScreenBlueValue
);
   typedef enum {IDLE, FETCH, ACCUM, COMPARE} lak_verify_type;

   logic [7:0] irqEnable;
   logic [7:0] irqFlags;
   logic [7:0] edgeConfig;
   logic [2:0] detSync;
   logic detStable;
   logic detPrev;
   logic [2:0] dsSync;
   logic dsStable;
   logic dsPrev;
   logic [4:0] evPrev;
   lak_verify_type state;
   logic verifyStart;
   logic verifyDone;
   logic verifyPassed;
   logic [KEY_WIDTH-1:0] hashAcc;
   logic [7:0] keyCount;
   logic wrEnable;
   logic wrVerify;
   logic wrEdge;
   logic wrBlue;
   logic rdStatus;
   logic detRise;
   logic detFall;
   logic detPulse;
   logic [7:0] eventSet;
   logic [6:1] pending;
   logic next_global;
   logic [4:0] evNow;
   logic [4:0] evRise;
   logic detRaw;

   // Digest step: rotate, mix and add; shortened in place of a full digest
   // Sum term keeps every key word in play, even from a zero start
   function automatic logic [KEY_WIDTH-1:0] mixStep(
      input logic [KEY_WIDTH-1:0] acc,
      input logic [KEY_WIDTH-1:0] word
   );
      mixStep = {acc[KEY_WIDTH-6:0], acc[KEY_WIDTH-1:KEY_WIDTH-5]}
         ^ (acc + word);
   endfunction

   function automatic logic hit(input logic [7:0] address,
                                input logic [7:0] target);
      hit = (address == target);
   endfunction

   assign wrEnable = bus.writeStrobe && hit(bus.address,
      lak_pkg::ADDR_IRQ_ENABLE);
   assign wrVerify = bus.writeStrobe && hit(bus.address,
      lak_pkg::ADDR_VERIFY_CTRL);
   assign wrEdge = bus.writeStrobe && hit(bus.address,
      lak_pkg::ADDR_EDGE_CONFIG);
   assign wrBlue = bus.writeStrobe && hit(bus.address,
      lak_pkg::ADDR_BLUE_VALUE);
   assign rdStatus = bus.readStrobe && hit(bus.address,
      lak_pkg::ADDR_IRQ_STATUS);

   assign detRaw = detectSourceSelect ? events.receiverLock
      : events.receiverDetect;

   // Pin inputs: three stages, change counts when stages two and three agree
   always_ff @(posedge clk) begin
      if (reset) begin
         detSync <= 3'h0;
         dsSync <= 3'h7;
      end else begin
         detSync <= {detSync[1:0], detRaw};
         dsSync <= {dsSync[1:0], events.downstreamIrqN};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         detStable <= 1'b0;
         dsStable <= 1'b1;
      end else begin
         if (detSync[1] == detSync[2]) begin
            detStable <= detSync[2];
         end
         if (dsSync[1] == dsSync[2]) begin
            dsStable <= dsSync[2];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         detPrev <= 1'b0;
         dsPrev <= 1'b1;
         evPrev <= 5'h00;
      end else begin
         detPrev <= detStable;
         dsPrev <= dsStable;
         evPrev <= evNow;
      end
   end

   assign detRise = detStable && !detPrev;
   assign detFall = !detStable && detPrev;
   assign detPulse = (detRise && edgeConfig[lak_pkg::BIT_RISING_PULSE])
      || (detFall && |edgeConfig[lak_pkg::FALL_MSB:lak_pkg::FALL_LSB]);

   // Engine events are same-clock logic; flags catch their rising edges
   assign evNow = {events.keyListReady, events.keyVectorReady,
      events.authFail, events.authPass, 1'b0};
   assign evRise = evNow & ~evPrev;

   always_comb begin
      eventSet = 8'h00;
      eventSet[lak_pkg::BIT_DETECT] = detPulse;
      eventSet[lak_pkg::BIT_DOWNSTREAM] = !dsStable && dsPrev;
      eventSet[lak_pkg::BIT_LIST_READY] = evRise[4];
      eventSet[lak_pkg::BIT_VECTOR_READY] = evRise[3];
      eventSet[lak_pkg::BIT_AUTH_FAIL] = evRise[2];
      eventSet[lak_pkg::BIT_AUTH_PASS] = evRise[1];
   end

   assign pending = irqFlags[6:1] & irqEnable[6:1];
   // Global status from any enabled source
   assign next_global = |pending;

   // Enable register, reserved bit kept zero
   always_ff @(posedge clk) begin
      if (reset) begin
         irqEnable <= lak_pkg::RESET_IRQ_ENABLE;
      end else if (wrEnable) begin
         irqEnable <= bus.writeData & lak_pkg::MASK_IRQ_ENABLE;
      end
   end

   // Latch on event, clear on read; a new event wins over the clear
   always_ff @(posedge clk) begin
      if (reset) begin
         irqFlags <= 8'h00;
      end else begin
         irqFlags[7] <= 1'b0;
         irqFlags[6:1] <= (rdStatus ? 6'h00 : irqFlags[6:1])
            | eventSet[6:1];
         irqFlags[0] <= 1'b0;
      end
   end

   // Global gate onto the interrupt pin
   always_ff @(posedge clk) begin
      if (reset) begin
         irqOut <= 1'b0;
      end else begin
         irqOut <= next_global && irqEnable[lak_pkg::BIT_GLOBAL];
      end
   end

   // Accept output is held low; no accept pulse is ever raised
   always_ff @(posedge clk) begin
      if (reset) begin
         keyVectorAccepted <= 1'b0;
      end else begin
         keyVectorAccepted <= wrEnable && 1'b0;
      end
   end

   // Edge config, reserved bits stay zero
   always_ff @(posedge clk) begin
      if (reset) begin
         edgeConfig <= lak_pkg::RESET_EDGE_CONFIG;
      end else if (wrEdge) begin
         edgeConfig <= {1'b0, bus.writeData[6:2], 2'b00};
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fillScreenBlueValue <= lak_pkg::RESET_BLUE_VALUE;
      end else if (wrBlue) begin
         fillScreenBlueValue <= bus.writeData;
      end
   end

   // Verify sequencer; start bit drops at completion
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= IDLE;
         verifyStart <= 1'b0;
         verifyDone <= 1'b0;
         verifyPassed <= 1'b0;
         hashAcc <= '0;
         keyCount <= 8'h00;
         keyIndex <= 8'h00;
      end else begin
         case (state)
            IDLE: begin
               if (wrVerify && bus.writeData[lak_pkg::BIT_VERIFY_START]) begin
                  verifyStart <= 1'b1;
                  verifyDone <= 1'b0;
                  verifyPassed <= 1'b0;
                  hashAcc <= '0;
                  keyCount <= 8'h00;
                  keyIndex <= 8'h00;
                  state <= FETCH;
               end
            end
            FETCH: begin
               state <= ACCUM;
            end
            ACCUM: begin
               hashAcc <= mixStep(hashAcc, keyWord);
               if (keyCount == 8'(KEY_COUNT - 1)) begin
                  state <= COMPARE;
               end else begin
                  keyCount <= keyCount + 8'h01;
                  keyIndex <= keyIndex + 8'h01;
                  state <= FETCH;
               end
            end
            COMPARE: begin
               verifyPassed <= (hashAcc == STORED_DIGEST);
               verifyDone <= 1'b1;
               verifyStart <= 1'b0;
               state <= IDLE;
            end
            default: begin
               state <= IDLE;
            end
         endcase
      end
   end

   // Read mux, unmapped and reserved read zero
   always_ff @(posedge clk) begin
      if (reset) begin
         readData <= 8'h00;
      end else if (bus.readStrobe) begin
         case (bus.address)
            lak_pkg::ADDR_IRQ_ENABLE: begin
               readData <= irqEnable;
            end
            lak_pkg::ADDR_IRQ_STATUS: begin
               readData <= {1'b0, irqFlags[6:1], next_global};
            end
            lak_pkg::ADDR_VERIFY_CTRL: begin
               readData <= {verifyPassed, verifyDone, 3'b000,
                  verifyStart, 2'b00};
            end
            lak_pkg::ADDR_EDGE_CONFIG: begin
               readData <= edgeConfig;
            end
            lak_pkg::ADDR_BLUE_VALUE: begin
               readData <= fillScreenBlueValue;
            end
            default: begin
               readData <= 8'h00;
            end
         endcase
      end else begin
         readData <= 8'h00;
      end
   end
endmodule

//--- sim/lak_link_auth_irq_properties.sv
// Port checker for the auth interrupt and key verify block
`timescale 1ns/1ps
module lak_link_auth_irq_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Watched ports
   input wire lak_pkg::lak_bus_type bus,
   input wire logic [7:0] readData,
   input wire logic irqOut,
   input wire logic keyVectorAccepted,
   input wire logic [7:0] fillScreenBlueValue
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence rdAt(logic [7:0] a);
      bus.readStrobe && bus.address == a;
   endsequence
   AST_IDLE_ZERO: assert property (
      !$past(bus.readStrobe) |-> readData == 8'h00)
      else $error("read data not zero outside a read");
   AST_UNMAPPED: assert property (
      rdAt(8'hc9) |=> readData == 8'h00) else $error("unmapped read");
   AST_TOP_BIT: assert property (
      (rdAt(8'hc6) or rdAt(8'hc7)) |=> !readData[7])
      else $error("reserved top bit set");
   AST_EDGE_RSVD: assert property (
      rdAt(8'hcd) |=> !readData[7] && readData[1:0] == 2'b00)
      else $error("edge config reserved bits set");
   AST_VFY_RSVD: assert property (
      rdAt(8'hc8) |=> readData[5:3] == 3'b000 && readData[1:0] == 2'b00)
      else $error("verify reserved bits set");
   AST_DONE_CLEARS_START: assert property (
      rdAt(8'hc8) |=> !(readData[6] && readData[2]))
      else $error("start still set with done");
   AST_PASS_NEEDS_DONE: assert property (
      rdAt(8'hc8) |=> readData[6] || !readData[7])
      else $error("pass without done");
   AST_GLOBAL_OFF: assert property (
      bus.writeStrobe && bus.address == 8'hc6 && !bus.writeData[0]
      |-> ##[1:3] !irqOut) else $error("irq with global enable off");
   AST_ACCEPT_LOW: assert property (
      keyVectorAccepted == 1'b0) else $error("accept strobe raised");
   cover property ($rose(irqOut));
   cover property (rdAt(8'hc8) ##1 readData[6]);
   cover property (bus.writeStrobe && bus.address == 8'hce);
endmodule

bind lak_link_auth_irq lak_link_auth_irq_checker chk (
   .clk(clk), .reset(reset), .bus(bus), .readData(readData),
   .irqOut(irqOut), .keyVectorAccepted(keyVectorAccepted),
   .fillScreenBlueValue(fillScreenBlueValue));

//--- sim/lak_key_store_model.sv
// Key store model answering one cycle after the address
`timescale 1ns/1ps
module lak_key_store_model #(
   parameter int KEY_WIDTH = 32
) (
   // Clock
   input wire logic clk,
   // Key read port
   input wire logic [7:0] keyIndex,
   output logic [KEY_WIDTH-1:0] keyWord,
   // Flips bit 0 of every key word to make the check fail
   input wire logic corrupt
);
   always_ff @(posedge clk) begin
      keyWord <= {KEY_WIDTH/8{~keyIndex}} ^ KEY_WIDTH'(corrupt);
   end
endmodule

//--- sim/test_lak_link_auth_irq.sv
// Self-checking bench for the auth interrupt and key verify block
`timescale 1ns/1ps
module test_lak_link_auth_irq;
   localparam int KC = 4;
   // Reference digest of the clean key store model
   function automatic logic [31:0] refDigest(int n);
      logic [31:0] acc;
      logic [31:0] w;
      acc = 32'h0;
      for (int i = 0; i < n; i++) begin
         w = {4{~8'(i)}};
         acc = {acc[26:0], acc[31:27]} ^ (acc + w);
      end
      refDigest = acc;
   endfunction
   localparam logic [31:0] DIGEST = refDigest(KC);
   logic clk = 1'b0;
   logic reset = 1'b1;
   lak_pkg::lak_bus_type bus = '0;
   // Downstream request line idles high
   lak_pkg::lak_events_type events = 7'h10;
   logic detectSourceSelect = 1'b0;
   logic corrupt = 1'b0;
   logic [7:0] readData, keyIndex, fillScreenBlueValue;
   logic [31:0] keyWord;
   logic irqOut, keyVectorAccepted;
   int n_fail = 0;
   int checked = 0;

   always #10 clk = ~clk;

   lak_link_auth_irq #(.KEY_COUNT(KC), .STORED_DIGEST(DIGEST)) uut (
      .clk(clk), .reset(reset), .bus(bus), .readData(readData),
      .events(events), .detectSourceSelect(detectSourceSelect),
      .keyIndex(keyIndex), .keyWord(keyWord), .irqOut(irqOut),
      .keyVectorAccepted(keyVectorAccepted),
      .fillScreenBlueValue(fillScreenBlueValue));
   lak_key_store_model model (
      .clk(clk), .keyIndex(keyIndex), .keyWord(keyWord),
      .corrupt(corrupt));

   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.writeStrobe <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] exp, logic [7:0] m = 8'hff);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.readStrobe <= 1'b0;
      #1 check($sformatf("reg %h", a), exp, readData & m);
   endtask
   task automatic setLine(int i, logic v);
      @(posedge clk);
      events[i] <= v;
      idle(8);
   endtask
   task automatic irqIs(logic v);
      // Look after the edge has settled the pin
      #1;
      check("irqOut", {7'h0, v}, {7'h0, irqOut});
   endtask
   task automatic t_reset;
      rd(8'hc6, 8'h00);
      rd(8'hc7, 8'h00);
      rd(8'hc8, 8'h00);
      rd(8'hcd, 8'h40);
      rd(8'hce, 8'hff);
      rd(8'hc9, 8'h00);
      irqIs(1'b0);
   endtask
   task automatic t_reserved;
      wr(8'hc6, 8'hff);
      rd(8'hc6, 8'h7f);
      wr(8'hcd, 8'hff);
      rd(8'hcd, 8'h7c);
      wr(8'hce, 8'h5a);
      rd(8'hce, 8'h5a);
      check("blue", 8'h5a, fillScreenBlueValue);
      wr(8'hcd, 8'h40);
   endtask
   task automatic t_sources;
      for (int i = 0; i < 4; i++) begin
         setLine(i, 1'b1);
         setLine(i, 1'b0);
         irqIs(1'b1);
         rd(8'hc7, 8'h01 | (8'h02 << i));
         rd(8'hc7, 8'h00);
         idle(3);
         irqIs(1'b0);
      end
   endtask
   task automatic t_masks;
      wr(8'hc6, 8'h01);
      setLine(1, 1'b1);
      setLine(1, 1'b0);
      irqIs(1'b0);
      rd(8'hc7, 8'h04);
      wr(8'hc6, 8'h7e);
      setLine(0, 1'b1);
      setLine(0, 1'b0);
      irqIs(1'b0);
      rd(8'hc7, 8'h03);
   endtask
   task automatic t_downstream;
      wr(8'hc6, 8'h21);
      setLine(4, 1'b0);
      irqIs(1'b1);
      rd(8'hc7, 8'h21);
      setLine(4, 1'b1);
      rd(8'hc7, 8'h00);
   endtask
   task automatic det(logic sel, logic [7:0] cfg, logic [7:0] r,
                      logic [7:0] f);
      wr(8'hcd, cfg);
      detectSourceSelect <= sel;
      setLine(5 + sel, 1'b1);
      setLine(5 + sel, 1'b0);
      rd(8'hc7, 8'h00);
      setLine(6 - sel, 1'b1);
      rd(8'hc7, r);
      setLine(6 - sel, 1'b0);
      rd(8'hc7, f);
   endtask
   task automatic t_detect;
      wr(8'hc6, 8'h41);
      det(1'b0, 8'h40, 8'h41, 8'h00);
      det(1'b0, 8'h3c, 8'h00, 8'h41);
      det(1'b0, 8'h7c, 8'h41, 8'h41);
      det(1'b1, 8'h40, 8'h41, 8'h00);
      det(1'b1, 8'h3c, 8'h00, 8'h41);
   endtask
   task automatic t_verify;
      wr(8'hc8, 8'h27);
      rd(8'hc8, 8'h04);
      idle(2 * KC + 4);
      rd(8'hc8, 8'hc0);
      corrupt <= 1'b1;
      wr(8'hc8, 8'h04);
      rd(8'hc8, 8'h04);
      idle(2 * KC + 4);
      rd(8'hc8, 8'h40);
      corrupt <= 1'b0;
   endtask
   task automatic t_midreset;
      wr(8'hcd, 8'h7c);
      @(posedge clk);
      reset <= 1'b1;
      idle(2);
      reset <= 1'b0;
      rd(8'hc6, 8'h00);
      rd(8'hc8, 8'h00);
      rd(8'hcd, 8'h40);
      irqIs(1'b0);
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      idle(12);
      reset <= 1'b0;
      t_reset();
      t_reserved();
      t_sources();
      t_masks();
      t_downstream();
      t_detect();
      t_verify();
      t_midreset();
      finish_test();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      idle(20000);
      n_fail++;
      finish_test();
   end
endmodule
